// ### hw/core_sfr_pkg.sv
package core_sfr_pkg;

	// Special-function register addresses, shared by every bank.
	localparam logic [7:0] BANK0_WINDOW_ADDR   = 8'h00;
	localparam logic [7:0] BANK0_POINTER_ADDR  = 8'h01;
	localparam logic [7:0] ANY_WINDOW_ADDR     = 8'h02;
	localparam logic [7:0] ANY_POINTER_ADDR    = 8'h03;
	localparam logic [7:0] BANK_SELECT_ADDR    = 8'h04;
	localparam logic [7:0] ACCUMULATOR_ADDR    = 8'h05;
	localparam logic [7:0] PROG_LOW_ADDR       = 8'h06;
	localparam logic [7:0] TABLE_LOW_ADDR      = 8'h07;
	localparam logic [7:0] TABLE_HIGH_BYTE_ADDR = 8'h08;
	localparam logic [7:0] TABLE_PAGE_ADDR     = 8'h09;
	localparam logic [7:0] STATUS_ADDR         = 8'h0A;
	localparam logic [7:0] SFR_AREA_END        = 8'h3F;

	// Status bit positions, and the bank bit of the bank select register.
	localparam int CARRY_BIT    = 0;
	localparam int AUX_BIT      = 1;
	localparam int ZERO_BIT     = 2;
	localparam int OVERFLOW_BIT = 3;
	localparam int POWER_BIT    = 4;
	localparam int TIMEOUT_BIT  = 5;
	localparam int BANK_BIT     = 0;

	// Values after reset.
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE     = 8'h00;
	localparam logic [3:0] ARITH_RESET   = 4'h0;

	// Flag update operation from the ALU.
	typedef enum logic [2:0]
	{
		ALU_NONE  = 3'h0,
		ALU_ADD   = 3'h1,
		ALU_SUB   = 3'h3,
		ALU_LOGIC = 3'h2,
		ALU_ROT   = 3'h6
	} alu_op_t;

endpackage

// ### hw/core_sfr_indirect_status.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RULE_01: Window accesses are redirected to the address held in the matching pointer.
// RULE_02: First pair reaches bank 0 only; second pair reaches bank chosen by select bit.
// RULE_03: Indirect access to a window location reads 00H and writes nothing.
// RULE_04: Both pointers are ordinary 8-bit read/write registers.
// RULE_05: Direct data-memory operands always go to bank 0.
// RULE_06: Bank select register holds one bit at position 0; upper bits read zero.
// RULE_07: Resets clear bank select, except watchdog time-out reset while powered down.
// RULE_08: Special-function area looks the same from every bank.
// RULE_09: Writing program-counter low jumps within page and inserts one dummy cycle.
// RULE_10: Table read fetches word at table pointers; high byte to table-high register.
// RULE_11: No register-to-register path; moves go through the accumulator.
// RULE_12: Software status writes change arithmetic flags only, not time-out or power-down.
// RULE_13: Time-out flag set by watchdog time-out; cleared by power-up, clear, halt.
// RULE_14: Power-down flag set by halt; cleared by power-up and watchdog clear.
// RULE_15: Carry set on add carry-out or subtract no-borrow; rotate-through-carry updates it.
// RULE_16: Aux carry set on low-nibble carry in add or no nibble borrow in subtract.
// RULE_17: Zero flag set when arithmetic or logical result is zero.
// RULE_18: Overflow set when carry into MSB differs from carry out of MSB.
// RULE_19: Status is never saved automatically on interrupt or call.
// RULE_20: Status bits 7 and 6 read zero; time-out and power-down read-only, reset zero.
// RULE_21: Software reaches bank-1 location 40H by pointer 40H and bank select 01H.
// RULE_22: Second pair address is bank-select bit concatenated with eight pointer bits.
module core_sfr_indirect_status
#(
	parameter int PROG_ADDR_W = 11
)
(
	// Clock and reset.
	input  wire logic                     sys_clk_i,
	input  wire logic                     reset_i,
	input  wire logic                     power_up_reset_i,
	input  wire logic                     wdt_reset_in_halt_i,
	// Core data access, one operand per cycle.
	input  wire logic                     acc_rd_i,
	input  wire logic                     acc_wr_i,
	input  wire logic [7:0]               acc_addr_i,
	input  wire logic [7:0]               acc_wdata_i,
	output logic      [7:0]               acc_rdata_o,
	// Data memory port, address is bank bit plus offset.
	output logic                          mem_rd_o,
	output logic                          mem_wr_o,
	output logic      [8:0]               mem_addr_o,
	output logic      [7:0]               mem_wdata_o,
	input  wire logic [7:0]               mem_rdata_i,
	// ALU flag update.
	input  wire core_sfr_pkg::alu_op_t    alu_op_i,
	input  wire logic [7:0]               alu_a_i,
	input  wire logic [7:0]               alu_b_i,
	input  wire logic                     alu_cin_i,
	input  wire logic                     rot_cout_i,
	input  wire logic [7:0]               alu_result_i,
	// System events.
	input  wire logic                     wdt_timeout_i,
	input  wire logic                     watchdog_clear_instr_i,
	input  wire logic                     halt_instr_i,
	// Program counter and table read.
	input  wire logic [PROG_ADDR_W-1:0]   pc_current_i,
	output logic                          pc_load_o,
	output logic      [PROG_ADDR_W-1:0]   pc_target_o,
	output logic                          dummy_cycle_o,
	input  wire logic                     table_rd_i,
	output logic      [15:0]              table_addr_o,
	input  wire logic [15:0]              table_word_i,
	input  wire logic                     table_word_valid_i,
	output logic      [7:0]               table_low_byte_o,
	output logic                          table_low_valid_o,
	// Register views.
	output logic      [7:0]               accumulator_o,
	output logic      [7:0]               status_o,
	output logic                          bank_select_bit_o
);
	import core_sfr_pkg::*;

	logic [7:0] bank0_mem_pointer_reg;
	logic [7:0] anybank_mem_pointer_reg;
	logic       bank_select_bit_reg;
	logic [7:0] accumulator_reg;
	logic [7:0] table_low_ptr_reg;
	logic [7:0] table_page_ptr_reg;
	logic [7:0] table_read_high_byte_reg;
	logic [3:0] arith_flags_reg;
	logic       watchdog_timeout_flag_reg;
	logic       power_down_flag_reg;
	logic [7:0] rdata_reg;
	logic       pc_load_reg;
	logic       dummy_cycle_reg;
	logic [7:0] low_byte_reg;
	logic       low_valid_reg;

	logic       is_win0;
	logic       is_win1;
	logic       is_sfr;
	logic [7:0] eff_off;
	logic       eff_bank;
	logic       target_is_window;
	logic       sfr_target;
	logic [7:0] sfr_rdata;
	logic [7:0] status_view;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic       c_into_msb;
	logic       sfr_wr;

	// Address resolution; the bank bit only matters behind the second window.
	always_comb
	begin
		is_win0 = (acc_addr_i == BANK0_WINDOW_ADDR);
		is_win1 = (acc_addr_i == ANY_WINDOW_ADDR);
		if (is_win0)
		begin
			eff_off  = bank0_mem_pointer_reg; // RULE_01
			eff_bank = 1'b0; // RULE_02
		end
		else if (is_win1)
		begin
			eff_off  = anybank_mem_pointer_reg; // RULE_01
			eff_bank = bank_select_bit_reg; // RULE_22
		end
		else
		begin
			eff_off  = acc_addr_i;
			eff_bank = 1'b0; // RULE_05
		end
		// Both windows decode the same whatever the pointer's bank.
		target_is_window = (is_win0 || is_win1) &&
			(eff_off == BANK0_WINDOW_ADDR || eff_off == ANY_WINDOW_ADDR); // RULE_03
		// The SFR area ignores the bank bit; offsets up to 3FH are registers in either bank.
		is_sfr     = (eff_off <= SFR_AREA_END); // RULE_08
		sfr_target = is_sfr && !target_is_window;
	end

	assign sfr_wr = acc_wr_i && sfr_target;

	// Status as seen by software; no path stacks it, so calls and interrupts leave it alone.
	assign status_view = {2'b00, watchdog_timeout_flag_reg, power_down_flag_reg,
		arith_flags_reg}; // RULE_20

	// SFR read mux; unlisted SFR locations read zero.
	always_comb
	begin
		case (eff_off)
			BANK0_POINTER_ADDR:   sfr_rdata = bank0_mem_pointer_reg;
			ANY_POINTER_ADDR:     sfr_rdata = anybank_mem_pointer_reg;
			BANK_SELECT_ADDR:     sfr_rdata = {7'h00, bank_select_bit_reg}; // RULE_06
			ACCUMULATOR_ADDR:     sfr_rdata = accumulator_reg;
			PROG_LOW_ADDR:        sfr_rdata = pc_current_i[7:0];
			TABLE_LOW_ADDR:       sfr_rdata = table_low_ptr_reg;
			TABLE_HIGH_BYTE_ADDR: sfr_rdata = table_read_high_byte_reg;
			TABLE_PAGE_ADDR:      sfr_rdata = table_page_ptr_reg;
			STATUS_ADDR:          sfr_rdata = status_view;
			default:              sfr_rdata = ZERO_BYTE;
		endcase
	end

	// Memory port; window targets never reach memory.
	assign mem_rd_o    = acc_rd_i && !is_sfr;
	assign mem_wr_o    = acc_wr_i && !is_sfr;
	assign mem_addr_o  = {eff_bank, eff_off};
	assign mem_wdata_o = acc_wdata_i;

	// Read data is registered one cycle after the request.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			rdata_reg <= ZERO_BYTE;
		else if (acc_rd_i)
		begin
			if (target_is_window)
				rdata_reg <= ZERO_BYTE; // RULE_03
			else if (is_sfr)
				rdata_reg <= sfr_rdata;
			else
				rdata_reg <= mem_rdata_i;
		end
	end

	// Pointers are plain registers.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			bank0_mem_pointer_reg   <= POINTER_RESET;
			anybank_mem_pointer_reg <= POINTER_RESET;
		end
		else if (sfr_wr)
		begin
			if (eff_off == BANK0_POINTER_ADDR)
				bank0_mem_pointer_reg <= acc_wdata_i; // RULE_04
			if (eff_off == ANY_POINTER_ADDR)
				anybank_mem_pointer_reg <= acc_wdata_i; // RULE_04
		end
	end

	// A watchdog reset from halt keeps the bank so the sleeping program resumes in place.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i && !wdt_reset_in_halt_i)
			bank_select_bit_reg <= 1'b0; // RULE_07
		else if (!reset_i && sfr_wr && eff_off == BANK_SELECT_ADDR)
			bank_select_bit_reg <= acc_wdata_i[BANK_BIT]; // RULE_06
	end

	// Accumulator is the only move path between registers.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			accumulator_reg <= ZERO_BYTE;
		else if (sfr_wr && eff_off == ACCUMULATOR_ADDR)
			accumulator_reg <= acc_wdata_i; // RULE_11
	end

	// Table pointers and the high byte of a table read.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			table_low_ptr_reg        <= ZERO_BYTE;
			table_page_ptr_reg       <= ZERO_BYTE;
			table_read_high_byte_reg <= ZERO_BYTE;
		end
		else
		begin
			if (sfr_wr && eff_off == TABLE_LOW_ADDR)
				table_low_ptr_reg <= acc_wdata_i;
			if (sfr_wr && eff_off == TABLE_PAGE_ADDR)
				table_page_ptr_reg <= acc_wdata_i;
			if (table_word_valid_i)
				table_read_high_byte_reg <= table_word_i[15:8]; // RULE_10
			else if (sfr_wr && eff_off == TABLE_HIGH_BYTE_ADDR)
				table_read_high_byte_reg <= acc_wdata_i;
		end
	end

	// Low byte is handed to the core for the instruction's destination.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			low_byte_reg  <= ZERO_BYTE;
			low_valid_reg <= 1'b0;
		end
		else
		begin
			low_valid_reg <= table_word_valid_i;
			if (table_word_valid_i)
				low_byte_reg <= table_word_i[7:0]; // RULE_10
		end
	end

	assign table_addr_o = {table_page_ptr_reg, table_low_ptr_reg}; // RULE_10

	// Writing the low counter byte jumps in the current page and costs one dummy cycle.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			pc_load_reg     <= 1'b0;
			dummy_cycle_reg <= 1'b0;
			pc_target_o     <= '0;
		end
		else
		begin
			pc_load_reg     <= sfr_wr && eff_off == PROG_LOW_ADDR; // RULE_09
			dummy_cycle_reg <= pc_load_reg; // RULE_09
			if (sfr_wr && eff_off == PROG_LOW_ADDR)
				pc_target_o <= {pc_current_i[PROG_ADDR_W-1:8], acc_wdata_i}; // RULE_09
		end
	end

	// Flag arithmetic; for subtract the core passes the inverted operand and carry-in.
	always_comb
	begin
		sum9       = {1'b0, alu_a_i} + {1'b0, alu_b_i} + {8'h00, alu_cin_i};
		nib5       = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]} + {4'h0, alu_cin_i};
		c_into_msb = alu_a_i[7] ^ alu_b_i[7] ^ sum9[7];
	end

	// Arithmetic flags; an ALU update in the same cycle wins over a software write.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			arith_flags_reg <= ARITH_RESET;
		else if (alu_op_i == ALU_ADD || alu_op_i == ALU_SUB)
		begin
			arith_flags_reg[CARRY_BIT]    <= sum9[8]; // RULE_15
			arith_flags_reg[AUX_BIT]      <= nib5[4]; // RULE_16
			arith_flags_reg[ZERO_BIT]     <= (alu_result_i == ZERO_BYTE); // RULE_17
			arith_flags_reg[OVERFLOW_BIT] <= c_into_msb ^ sum9[8]; // RULE_18
		end
		else if (alu_op_i == ALU_LOGIC)
			arith_flags_reg[ZERO_BIT] <= (alu_result_i == ZERO_BYTE); // RULE_17
		else if (alu_op_i == ALU_ROT)
			arith_flags_reg[CARRY_BIT] <= rot_cout_i; // RULE_15
		else if (sfr_wr && eff_off == STATUS_ADDR)
			arith_flags_reg <= acc_wdata_i[3:0]; // RULE_12
	end

	// System flags ignore software writes; a time-out beats a simultaneous clear.
	always_ff @(posedge sys_clk_i)
	begin
		if (power_up_reset_i)
		begin
			watchdog_timeout_flag_reg <= 1'b0; // RULE_13
			power_down_flag_reg       <= 1'b0; // RULE_14
		end
		else
		begin
			if (wdt_timeout_i)
				watchdog_timeout_flag_reg <= 1'b1; // RULE_13
			else if (watchdog_clear_instr_i || halt_instr_i)
				watchdog_timeout_flag_reg <= 1'b0; // RULE_13
			if (halt_instr_i)
				power_down_flag_reg <= 1'b1; // RULE_14
			else if (watchdog_clear_instr_i)
				power_down_flag_reg <= 1'b0; // RULE_14
		end
	end

	assign acc_rdata_o       = rdata_reg;
	assign pc_load_o         = pc_load_reg;
	assign dummy_cycle_o     = dummy_cycle_reg;
	assign table_low_byte_o  = low_byte_reg;
	assign table_low_valid_o = low_valid_reg;
	assign accumulator_o     = accumulator_reg;
	assign status_o          = status_view; // RULE_19
	assign bank_select_bit_o = bank_select_bit_reg;

endmodule

`default_nettype wire

// ### sim/data_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module data_mem_model
(
	// Memory port.
	input  wire logic       clk_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [8:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem [512];

	// Each bank holds distinct bytes and the banks differ at every offset, so a wrong bank or offset reads back wrong.
	initial for (int i = 0; i < 512; i++) mem[i] = 8'(i ^ (i >> 1));

	// Writes land on the clock edge.
	always @(posedge clk_i) if (wr_i) mem[addr_i] <= wdata_i;

	// Outside a read the data is inverted, so a stale sample never looks right.
	assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
endmodule
`default_nettype wire

// ### sim/core_sfr_indirect_status_properties.sv
`timescale 1ns/100ps
`default_nettype none
module core_sfr_indirect_status_properties
#(
	parameter int PROG_ADDR_W = 11
)
(
	// Clock and resets.
	input wire logic                   sys_clk_i,
	input wire logic                   reset_i,
	input wire logic                   power_up_reset_i,
	input wire logic                   wdt_reset_in_halt_i,
	// Core access and memory port.
	input wire logic                   acc_rd_i,
	input wire logic                   acc_wr_i,
	input wire logic [7:0]             acc_addr_i,
	input wire logic [7:0]             acc_wdata_i,
	input wire logic                   mem_rd_o,
	input wire logic                   mem_wr_o,
	input wire logic [8:0]             mem_addr_o,
	// Flags and events.
	input wire core_sfr_pkg::alu_op_t  alu_op_i,
	input wire logic [7:0]             alu_result_i,
	input wire logic                   wdt_timeout_i,
	input wire logic                   watchdog_clear_instr_i,
	input wire logic                   halt_instr_i,
	input wire logic [7:0]             status_o,
	input wire logic                   bank_select_bit_o,
	// Program counter.
	input wire logic                   pc_load_o,
	input wire logic [PROG_ADDR_W-1:0] pc_target_o,
	input wire logic                   dummy_cycle_o
);
	import core_sfr_pkg::*;

	// Everything here lives in the one system clock domain.
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	chk_direct_bank0: assert property (
		acc_rd_i && acc_addr_i > SFR_AREA_END |-> mem_rd_o && mem_addr_o == {1'b0, acc_addr_i})
		else $error("direct read missed bank 0");
	chk_sfr_no_mem: assert property (
		(acc_rd_i || acc_wr_i) && acc_addr_i <= SFR_AREA_END && acc_addr_i != BANK0_WINDOW_ADDR
		&& acc_addr_i != ANY_WINDOW_ADDR |-> !mem_rd_o && !mem_wr_o)
		else $error("register access reached memory");
	chk_window0_bank: assert property (
		acc_addr_i == BANK0_WINDOW_ADDR && (mem_rd_o || mem_wr_o) |-> !mem_addr_o[8])
		else $error("first window left bank 0");
	chk_window1_bank: assert property (
		acc_addr_i == ANY_WINDOW_ADDR && (mem_rd_o || mem_wr_o) |-> mem_addr_o[8] == bank_select_bit_o)
		else $error("second window bank wrong");
	chk_pcl_jump: assert property (
		acc_wr_i && acc_addr_i == PROG_LOW_ADDR |=> pc_load_o && pc_target_o[7:0] == $past(acc_wdata_i)
		##1 dummy_cycle_o && !pc_load_o)
		else $error("jump or dummy cycle wrong");
	chk_bank_reset: assert property (disable iff (1'b0)
		reset_i |=> bank_select_bit_o == ($past(wdt_reset_in_halt_i) ? $past(bank_select_bit_o) : 1'b0))
		else $error("bank select after reset wrong");
	chk_timeout_set: assert property (
		wdt_timeout_i && !power_up_reset_i |=> status_o[TIMEOUT_BIT])
		else $error("time-out flag not set");
	chk_halt_flags: assert property (
		halt_instr_i && !wdt_timeout_i && !power_up_reset_i |=> status_o[5:4] == 2'b01)
		else $error("halt flags wrong");
	chk_wdt_clear: assert property (
		watchdog_clear_instr_i && !halt_instr_i && !wdt_timeout_i |=> status_o[5:4] == 2'b00)
		else $error("watchdog clear left flags");
	chk_sw_status: assert property (
		acc_wr_i && acc_addr_i == STATUS_ADDR && alu_op_i == ALU_NONE && !(wdt_timeout_i
		|| halt_instr_i || watchdog_clear_instr_i || power_up_reset_i)
		|=> status_o == {2'b00, $past(status_o[5:4]), $past(acc_wdata_i[3:0])})
		else $error("status write wrong");
	chk_zero_flag: assert property (
		alu_op_i == ALU_LOGIC |=> status_o[ZERO_BIT] == ($past(alu_result_i) == 8'h00))
		else $error("zero flag wrong");
	chk_status_top: assert property (
		status_o[7:6] == 2'b00)
		else $error("status top bits set");
endmodule
`default_nettype wire

// ### sim/tb_core_sfr_indirect_status.sv
`timescale 1ns/100ps
`default_nettype none
module tb_core_sfr_indirect_status;
	import core_sfr_pkg::*;
	typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data;} row_t;
	logic sys_clk_i, reset_i, power_up_reset_i, wdt_reset_in_halt_i, acc_rd_i, acc_wr_i;
	logic alu_cin_i, rot_cout_i, wdt_timeout_i, watchdog_clear_instr_i, halt_instr_i;
	logic table_rd_i, table_word_valid_i, mem_rd_o, mem_wr_o, pc_load_o, dummy_cycle_o;
	logic table_low_valid_o, bank_select_bit_o;
	logic [7:0] acc_addr_i, acc_wdata_i, acc_rdata_o, mem_wdata_o, mem_rdata_i, alu_a_i;
	logic [7:0] alu_b_i, alu_result_i, table_low_byte_o, accumulator_o, status_o;
	logic [7:0] seen = 8'h00;
	logic [8:0] mem_addr_o;
	logic [10:0] pc_current_i, pc_target_o;
	logic [15:0] table_addr_o, table_word_i;
	alu_op_t alu_op_i;
	int n_mismatch = 0;
	int checks_done = 0;
	// Writes carry data, reads carry the expected byte.
	row_t rows [25] = '{
		'{1, 8'h01, 8'h45}, '{0, 8'h01, 8'h45}, '{1, 8'h00, 8'h3C}, '{1, 8'h03, 8'h50},
		'{1, 8'h04, 8'hFF}, '{0, 8'h04, 8'h01}, '{0, 8'h01, 8'h45}, '{1, 8'h02, 8'h77},
		'{0, 8'h02, 8'h77}, '{0, 8'h50, 8'h78}, '{0, 8'h00, 8'h3C}, '{1, 8'h03, 8'h00},
		'{0, 8'h02, 8'h00}, '{1, 8'h02, 8'h99}, '{0, 8'h00, 8'h3C}, '{1, 8'h03, 8'h02},
		'{0, 8'h02, 8'h00}, '{1, 8'h04, 8'h00}, '{1, 8'h03, 8'h50}, '{0, 8'h02, 8'h78},
		'{1, 8'h0A, 8'hFF}, '{0, 8'h0A, 8'h0F}, '{0, 8'h3F, 8'h00}, '{1, 8'h07, 8'h34},
		'{1, 8'h09, 8'h12}};

	core_sfr_indirect_status #(.PROG_ADDR_W(11)) dut (.sys_clk_i, .reset_i, .power_up_reset_i,
		.wdt_reset_in_halt_i, .acc_rd_i, .acc_wr_i, .acc_addr_i, .acc_wdata_i, .acc_rdata_o,
		.mem_rd_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .alu_op_i, .alu_a_i,
		.alu_b_i, .alu_cin_i, .rot_cout_i, .alu_result_i, .wdt_timeout_i, .watchdog_clear_instr_i,
		.halt_instr_i, .pc_current_i, .pc_load_o, .pc_target_o, .dummy_cycle_o, .table_rd_i,
		.table_addr_o, .table_word_i, .table_word_valid_i, .table_low_byte_o, .table_low_valid_o,
		.accumulator_o, .status_o, .bank_select_bit_o);
	data_mem_model mem_model (.clk_i(sys_clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

	// Free-running 125 MHz clock.
	initial
	begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (n_mismatch == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One operand access; a read is compared once its registered data has landed.
	task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
		@(posedge sys_clk_i);
		acc_wr_i <= w;
		acc_rd_i <= !w;
		acc_addr_i <= ad;
		acc_wdata_i <= d;
		@(posedge sys_clk_i);
		acc_wr_i <= 1'b0;
		acc_rd_i <= 1'b0;
		#1;
		if (!w) chk(acc_rdata_o, d);
	endtask

	task automatic alu(input alu_op_t o, input logic [7:0] a, b, input logic c,
		input logic [7:0] r, m, e);
		@(posedge sys_clk_i);
		alu_op_i <= o;
		alu_a_i <= a;
		alu_b_i <= b;
		alu_cin_i <= c;
		rot_cout_i <= c;
		alu_result_i <= r;
		@(posedge sys_clk_i);
		alu_op_i <= ALU_NONE;
		#1 chk(status_o & m, e);
	endtask

	task automatic ev(input logic h, t, c, p, input logic [1:0] e);
		@(posedge sys_clk_i);
		{halt_instr_i, wdt_timeout_i, watchdog_clear_instr_i, power_up_reset_i} <= {h, t, c, p};
		@(posedge sys_clk_i);
		{halt_instr_i, wdt_timeout_i, watchdog_clear_instr_i, power_up_reset_i} <= 4'h0;
		#1 chk(status_o[5:4], e);
	endtask

	task automatic rst(input logic wh, input logic e);
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		wdt_reset_in_halt_i <= wh;
		@(posedge sys_clk_i);
		reset_i <= 1'b0;
		wdt_reset_in_halt_i <= 1'b0;
		#1 chk(bank_select_bit_o, e);
	endtask

	// Main sequence: register table first, then the awkward cases by hand.
	initial
	begin
		{reset_i, power_up_reset_i} = 2'b11;
		{wdt_reset_in_halt_i, acc_rd_i, acc_wr_i, alu_cin_i, rot_cout_i} = 5'h00;
		{wdt_timeout_i, watchdog_clear_instr_i, halt_instr_i, table_rd_i, table_word_valid_i} = 5'h00;
		{acc_addr_i, acc_wdata_i, alu_a_i, alu_b_i, alu_result_i} = 40'h0;
		{table_word_i, pc_current_i} = {16'h0000, 11'h5A3};
		alu_op_i = ALU_NONE;
		repeat (5) @(posedge sys_clk_i);
		{reset_i, power_up_reset_i} <= 2'b00;
		foreach (rows[i]) acc(rows[i].wr, rows[i].addr, rows[i].data);
		chk(table_addr_o, 16'h1234);
		@(posedge sys_clk_i);
		{table_word_i, table_word_valid_i, table_rd_i} <= {16'hABCD, 2'b11};
		@(posedge sys_clk_i);
		{table_word_valid_i, table_rd_i} <= 2'b00;
		repeat (3) @(negedge sys_clk_i) if (table_low_valid_o === 1'b1) seen = table_low_byte_o;
		chk(seen, 8'hCD);
		acc(0, TABLE_HIGH_BYTE_ADDR, 8'hAB);
		acc(1, PROG_LOW_ADDR, 8'h3C);
		chk({pc_load_o, pc_target_o}, 16'h0D3C);
		@(posedge sys_clk_i);
		#1 chk({dummy_cycle_o, pc_load_o}, 2'b10);
		alu(ALU_ADD, 8'h7F, 8'h01, 0, 8'h80, 8'h0F, 8'h0A);
		alu(ALU_ADD, 8'hFF, 8'h01, 0, 8'h00, 8'h0F, 8'h07);
		alu(ALU_SUB, 8'h05, 8'hFA, 1, 8'h00, 8'h0F, 8'h07);
		alu(ALU_SUB, 8'h03, 8'hFA, 1, 8'hFE, 8'h0F, 8'h00);
		alu(ALU_ROT, 8'h00, 8'h00, 1, 8'h00, 8'h01, 8'h01);
		alu(ALU_ROT, 8'h00, 8'h00, 0, 8'h00, 8'h01, 8'h00);
		alu(ALU_LOGIC, 8'h00, 8'h00, 0, 8'h00, 8'h04, 8'h04);
		alu(ALU_LOGIC, 8'h00, 8'h00, 0, 8'h5A, 8'h04, 8'h00);
		ev(1, 0, 0, 0, 2'b01);
		acc(1, STATUS_ADDR, 8'hF0);
		acc(0, STATUS_ADDR, 8'h10);
		ev(0, 1, 0, 0, 2'b11);
		ev(0, 0, 1, 0, 2'b00);
		ev(0, 1, 0, 0, 2'b10);
		ev(1, 0, 0, 0, 2'b01);
		ev(0, 0, 0, 1, 2'b00);
		acc(1, BANK_SELECT_ADDR, 8'h01);
		rst(1, 1'b1);
		rst(0, 1'b0);
		acc(0, BANK0_POINTER_ADDR, 8'h00);
		// The bank-1 control location: pointer 40H and bank 01H reach memory at 140H.
		acc(1, ANY_POINTER_ADDR, 8'h40);
		acc(1, BANK_SELECT_ADDR, 8'h01);
		acc(1, ANY_WINDOW_ADDR, 8'h5A);
		acc(0, ANY_WINDOW_ADDR, 8'h5A);
		acc(0, 8'h40, 8'h60);
		// Moves between registers pass through the accumulator.
		acc(1, ACCUMULATOR_ADDR, 8'hC3);
		chk(accumulator_o, 8'hC3);
		acc(0, ACCUMULATOR_ADDR, 8'hC3);
		tally_and_finish;
	end

	// A hang is cut short well beyond the roughly 120 cycles the tests need.
	initial
	begin
		repeat (3000) @(posedge sys_clk_i);
		n_mismatch++;
		tally_and_finish;
	end
endmodule

bind core_sfr_indirect_status core_sfr_indirect_status_properties #(.PROG_ADDR_W(PROG_ADDR_W))
	props (.sys_clk_i, .reset_i, .power_up_reset_i, .wdt_reset_in_halt_i, .acc_rd_i, .acc_wr_i,
	.acc_addr_i, .acc_wdata_i, .mem_rd_o, .mem_wr_o, .mem_addr_o, .alu_op_i, .alu_result_i,
	.wdt_timeout_i, .watchdog_clear_instr_i, .halt_instr_i, .status_o, .bank_select_bit_o,
	.pc_load_o, .pc_target_o, .dummy_cycle_o);
`default_nettype wire
